// file: design/ncb_top.sv
// Oscillator sync, mixing, channel bonding and double-rate output path
`timescale 1ns/1ps
`include "ncb_regs.svh"

module ncb_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic in_valid,
  input wire logic signed [15:0] duc_i [4],
  input wire logic signed [15:0] duc_q [4],
  input wire logic signed [15:0] nco_cos [4],
  input wire logic signed [15:0] nco_sin [4],
  input wire logic sysref,
  input wire logic fast_reconfig_frame_strobe,
  output logic [15:0] nco_phase [4],
  output logic nco_update,
  output logic dac_valid,
  output logic signed [15:0] dac_even,
  output logic signed [15:0] dac_odd,
  output logic signed [15:0] dac_q
);

  // =====================================================
  // Registers
  logic [31:0] ctrl;
  logic [11:0] nco_mode;
  logic [7:0] gain;
  logic [4:0] sum_src;
  logic [31:0] freq_word [4];
  logic [7:0] event_count;
  logic aw_full;
  logic w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_word;
  logic sync_fire;
  logic lsb_active;

  assign wr_fire = aw_full && w_full && !s_axi_bvalid;

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = data[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // =====================================================
  // AXI write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_full <= 1'b0;
    end else begin
      s_axi_awready <= !aw_full && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_full <= 1'b0;
    end else begin
      s_axi_wready <= !w_full && !s_axi_bvalid;
    end
  end

  always_comb begin
    wr_hit = (aw_addr[1:0] == 2'h0) && (aw_addr <= `NCB_FREQ3);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `NCB_RESP_OK;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `NCB_RESP_OK : `NCB_RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register: a software write lands after the automatic clear,
  // so a fresh sync request in the same cycle is never lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `NCB_CTRL_RST;
    end else begin
      if (sync_fire && ctrl[`NCB_FAST_RECONFIG_ENABLE]) begin
        ctrl[`NCB_SW_SYNC] <= 1'b0;
      end
      if (wr_fire && aw_addr == `NCB_CTRL) begin
        ctrl <= merge(ctrl, w_data, w_strb);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nco_mode <= 12'h000;
      gain <= 8'h00;
      sum_src <= 5'(`NCB_SUM_SRC_RST);
      freq_word <= '{default: 32'h0000_0000};
    end else if (wr_fire) begin
      case (aw_addr)
        `NCB_NCO_MODE: nco_mode <= 12'(merge(32'(nco_mode), w_data,
          w_strb));
        `NCB_GAIN: gain <= 8'(merge(32'(gain), w_data, w_strb));
        `NCB_SUM_SRC: sum_src <= 5'(merge(32'(sum_src), w_data,
          w_strb));
        default: begin
          if (aw_addr >= `NCB_FREQ0 && aw_addr <= `NCB_FREQ3
              && aw_addr[1:0] == 2'h0) begin
            freq_word[aw_addr[3:2]] <= merge(freq_word[aw_addr[3:2]],
              w_data, w_strb);
          end
        end
      endcase
    end
  end

  // =====================================================
  // AXI read channel
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `NCB_CTRL: rd_word = ctrl;
      `NCB_NCO_MODE: rd_word = 32'(nco_mode);
      `NCB_GAIN: rd_word = 32'(gain);
      `NCB_SUM_SRC: rd_word = 32'(sum_src);
      `NCB_STATUS: rd_word = {16'h0000, event_count, 7'h00, lsb_active};
      default: begin
        rd_word = freq_word[s_axi_araddr[3:2]];
        rd_hit = s_axi_araddr >= `NCB_FREQ0
          && s_axi_araddr <= `NCB_FREQ3 && s_axi_araddr[1:0] == 2'h0;
        if (!rd_hit) begin
          rd_word = 32'h0000_0000;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `NCB_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? `NCB_RESP_OK : `NCB_RESP_ERR;
    end else if (s_axi_rvalid) begin
      s_axi_rvalid <= !s_axi_rready;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // =====================================================
  // Trigger sources
  logic [1:0] sysref_sync;
  logic [1:0] frame_sync;
  logic sysref_last;
  logic frame_last;
  logic sw_last;
  logic [2:0] low_run;
  logic [2:0] high_run;
  logic trig;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sysref_sync <= 2'h0;
      frame_sync <= 2'h0;
      sysref_last <= 1'b0;
      frame_last <= 1'b0;
      sw_last <= 1'b0;
    end else begin
      sysref_sync <= {sysref_sync[0], sysref};
      frame_sync <= {frame_sync[0], fast_reconfig_frame_strobe};
      sysref_last <= sysref_sync[1];
      frame_last <= frame_sync[1];
      sw_last <= ctrl[`NCB_SW_SYNC];
    end
  end

  // Replacement needs the software bit, source 3 and a complex link
  assign lsb_active = ctrl[`NCB_SW_SYNC]
    && ctrl[`NCB_SRC_LO +: 2] == `NCB_TRIG_LSB
    && ctrl[`NCB_CPLX_LINK];

  // Low run saturates at four; a high run only counts after it
  always_ff @(posedge aclk) begin
    if (!aresetn || !lsb_active) begin
      low_run <= 3'h0;
      high_run <= 3'h0;
    end else if (in_valid) begin
      if (!duc_i[0][0]) begin
        high_run <= 3'h0;
        low_run <= (low_run == `NCB_LSB_RUN) ? low_run
          : low_run + 3'h1;
      end else if (low_run != `NCB_LSB_RUN || sync_fire) begin
        low_run <= 3'h0;
        high_run <= 3'h0;
      end else begin
        high_run <= high_run + 3'h1;
      end
    end
  end

  assign sync_fire = lsb_active && in_valid && duc_i[0][0]
    && low_run == `NCB_LSB_RUN
    && high_run == `NCB_LSB_RUN - 3'h1;

  always_comb begin
    case (ctrl[`NCB_SRC_LO +: 2])
      `NCB_TRIG_SW: trig = ctrl[`NCB_SW_SYNC] && !sw_last;
      `NCB_TRIG_SYSREF: trig = sysref_sync[1] && !sysref_last;
      `NCB_TRIG_FRAME: trig = frame_sync[1] && !frame_last
        && ctrl[`NCB_FAST_UPD];
      default: trig = sync_fire;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nco_update <= 1'b0;
      event_count <= 8'h00;
    end else begin
      nco_update <= trig;
      event_count <= event_count + 8'(trig);
    end
  end

  // =====================================================
  // Oscillator accumulators, one per converter
  logic [31:0] sample_count;
  logic [31:0] acc [4];
  logic [31:0] freq_live [4];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_count <= 32'h0000_0000;
    end else if (in_valid) begin
      sample_count <= sample_count + 32'h0000_0001;
    end
  end

  genvar n;
  generate
    for (n = 0; n < 4; n++) begin : g_nco
      ncb_pkg::ncb_mode_e mode;
      logic reset_sel;
      logic [63:0] coherent;
      assign reset_sel = ctrl[`NCB_FAST_RECONFIG_ENABLE] ? nco_mode[`NCB_FAR_LO + n]
        : nco_mode[`NCB_AR_LO + n];
      assign coherent = freq_word[n] * sample_count;
      always_comb begin
        case ({reset_sel, nco_mode[`NCB_CONT_LO + n]})
          2'b00: mode = ncb_pkg::ncb_mode_coherent;
          2'b01: mode = ncb_pkg::ncb_mode_continuous;
          default: mode = ncb_pkg::ncb_mode_reset;
        endcase
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          freq_live[n] <= 32'h0000_0000;
          acc[n] <= 32'h0000_0000;
        end else if (trig) begin
          freq_live[n] <= freq_word[n];
          case (mode)
            ncb_pkg::ncb_mode_reset: acc[n] <= 32'h0000_0000;
            ncb_pkg::ncb_mode_continuous: acc[n] <= acc[n];
            ncb_pkg::ncb_mode_coherent: acc[n] <= coherent[31:0];
            default: acc[n] <= 32'h0000_0000;
          endcase
        end else if (in_valid) begin
          acc[n] <= acc[n] + freq_live[n];
        end
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          nco_phase[n] <= 16'h0000;
        end else begin
          nco_phase[n] <= acc[n][31:16];
        end
      end
    end
  endgenerate

  // =====================================================
  // Input stage, mixers and bonder
  logic signed [15:0] in_i0;
  logic signed [15:0] mix_re [4];
  logic signed [15:0] mix_im [4];
  logic [2:0] vpipe;
  logic signed [19:0] sum_re;
  logic signed [19:0] sum_im;
  logic signed [15:0] bond_i;
  logic signed [15:0] bond_q;
  logic signed [15:0] raw_d;
  logic signed [15:0] raw_dd;

  // Sync flag is stripped so it never reaches the mixer as data
  assign in_i0 = lsb_active ? {duc_i[0][15:1], 1'b0} : duc_i[0];

  generate
    for (n = 0; n < 4; n++) begin : g_mix
      ncb_mixer u_mix (
        .aclk(aclk),
        .aresetn(aresetn),
        .en(in_valid),
        .real_mode(ctrl[`NCB_MIX_REAL]),
        .in_i(n == 0 ? in_i0 : duc_i[n]),
        .in_q(duc_q[n]),
        .lo_cos(nco_cos[n]),
        .lo_sin(nco_sin[n]),
        .out_re(mix_re[n]),
        .out_im(mix_im[n])
      );
    end
  endgenerate

  // Two guard fractional bits keep gains of 0.5 and 0.25 exact
  always_comb begin
    sum_re = 20'sh00000;
    sum_im = 20'sh00000;
    for (int c = 0; c < 4; c++) begin
      if (sum_src[c] && (!sum_src[`NCB_SUM_CPLX] || c < 2)) begin
        sum_re = sum_re + ((20'(mix_re[c]) <<< 2) >>> gain[2*c +: 2]);
        sum_im = sum_im + ((20'(mix_im[c]) <<< 2) >>> gain[2*c +: 2]);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vpipe <= 3'h0;
      bond_i <= 16'sh0000;
      bond_q <= 16'sh0000;
      raw_d <= 16'sh0000;
      raw_dd <= 16'sh0000;
    end else begin
      vpipe <= {vpipe[1:0], in_valid};
      if (in_valid) begin
        raw_d <= in_i0;
      end
      if (vpipe[0]) begin
        raw_dd <= raw_d;
        bond_i <= ncb_pkg::ncb_sat16((36'(sum_re) + 36'sh0_0000_0002)
          >>> 2);
        bond_q <= sum_src[`NCB_SUM_CPLX]
          ? ncb_pkg::ncb_sat16((36'(sum_im) + 36'sh0_0000_0002) >>> 2)
          : 16'sh0000;
      end
    end
  end

  // =====================================================
  // Double-rate output
  ncb_pkg::ncb_omode_e omode;
  logic signed [15:0] des_in;
  logic signed [15:0] hb_even;
  logic signed [15:0] hb_odd;

  always_comb begin
    case (ctrl[`NCB_OMODE_LO +: 2])
      `NCB_OM_DES_LP: omode = ncb_pkg::ncb_out_lowpass;
      `NCB_OM_DES_HP: omode = ncb_pkg::ncb_out_highpass;
      default: omode = ncb_pkg::ncb_out_direct;
    endcase
  end

  assign des_in = ctrl[`NCB_DES_SRC] ? raw_dd : bond_i;

  ncb_halfband u_hb (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(vpipe[1]),
    .highpass(omode == ncb_pkg::ncb_out_highpass),
    .din(des_in),
    .dout_even(hb_even),
    .dout_odd(hb_odd)
  );

  // Direct mode repeats each sample so both halves of the pair agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_valid <= 1'b0;
      dac_even <= 16'sh0000;
      dac_odd <= 16'sh0000;
      dac_q <= 16'sh0000;
    end else begin
      dac_valid <= vpipe[2];
      dac_q <= bond_q;
      if (omode == ncb_pkg::ncb_out_direct) begin
        dac_even <= bond_i;
        dac_odd <= bond_i;
      end else begin
        dac_even <= hb_even;
        dac_odd <= hb_odd;
      end
    end
  end

endmodule : ncb_top

// file: shared/ncb_regs.svh
// Register offsets, field positions, reset values and counts for ncb_top
`ifndef NCB_REGS_SVH
`define NCB_REGS_SVH

// =====================================================
// Register byte offsets
`define NCB_CTRL 8'h00
`define NCB_NCO_MODE 8'h04
`define NCB_GAIN 8'h08
`define NCB_SUM_SRC 8'h0c
`define NCB_FREQ0 8'h10
`define NCB_FREQ3 8'h1c
`define NCB_STATUS 8'h20

// =====================================================
// Control register fields
`define NCB_SW_SYNC 0
`define NCB_SRC_LO 1
`define NCB_FAST_UPD 3
`define NCB_FAST_RECONFIG_ENABLE 4
`define NCB_CPLX_LINK 5
`define NCB_MIX_REAL 6
`define NCB_OMODE_LO 7
`define NCB_DES_SRC 9
`define NCB_CTRL_RST 32'h0000_0020

// Mode register fields: four bits each, one per oscillator
`define NCB_AR_LO 0
`define NCB_CONT_LO 4
`define NCB_FAR_LO 8

// Sum source register: enable per converter, then complex flag
`define NCB_SUM_CPLX 4
`define NCB_SUM_SRC_RST 32'h0000_0001

// =====================================================
// Trigger source codes
`define NCB_TRIG_SW 2'h0
`define NCB_TRIG_SYSREF 2'h1
`define NCB_TRIG_FRAME 2'h2
`define NCB_TRIG_LSB 2'h3

// Output mode codes
`define NCB_OM_DES_LP 2'h1
`define NCB_OM_DES_HP 2'h2

// Sync run length in samples
`define NCB_LSB_RUN 3'h4

// Half-band outer taps, outermost first; centre tap is a shift by 11
`define NCB_HB_SHIFT 11
`define NCB_HB_COEFS '{-12'sh009, 12'sh013, -12'sh027, 12'sh046, \
  -12'sh07a, 12'sh0d3, -12'sh193, 12'sh50d}

// AXI response codes
`define NCB_RESP_OK 2'h0
`define NCB_RESP_ERR 2'h2

`endif

// file: shared/ncb_pkg.sv
// Types and shared saturation helper for the up-conversion back end
package ncb_pkg;

  // =====================================================
  // Oscillator update modes
  typedef enum logic [2:0] {
    ncb_mode_coherent = 3'b001,
    ncb_mode_continuous = 3'b010,
    ncb_mode_reset = 3'b100
  } ncb_mode_e;

  // Output path modes
  typedef enum logic [2:0] {
    ncb_out_direct = 3'b001,
    ncb_out_lowpass = 3'b010,
    ncb_out_highpass = 3'b100
  } ncb_omode_e;

  function automatic logic signed [15:0] ncb_sat16(
    input logic signed [35:0] v
  );
    if (v > 36'sh0_0000_7fff) begin
      return 16'sh7fff;
    end else if (v < -36'sh0_0000_8000) begin
      return -16'sh8000;
    end
    return v[15:0];
  endfunction : ncb_sat16

endpackage : ncb_pkg

// file: design/ncb_mixer.sv
// Complex mixer with one-to-one scaling and output saturation
`timescale 1ns/1ps
module ncb_mixer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic en,
  input wire logic real_mode,
  input wire logic signed [15:0] in_i,
  input wire logic signed [15:0] in_q,
  input wire logic signed [15:0] lo_cos,
  input wire logic signed [15:0] lo_sin,
  output logic signed [15:0] out_re,
  output logic signed [15:0] out_im
);
  logic signed [35:0] re_full;
  logic signed [35:0] im_full;

  // Oscillator is Q1.15, so a shift by 15 keeps the gain at exactly one
  always_comb begin
    re_full = (36'(in_i * lo_cos) - 36'(in_q * lo_sin)
      + 36'sh0_0000_4000) >>> 15;
    im_full = (36'(in_i * lo_sin) + 36'(in_q * lo_cos)
      + 36'sh0_0000_4000) >>> 15;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_re <= 16'sh0000;
      out_im <= 16'sh0000;
    end else if (en) begin
      // Magnitudes above full scale clip rather than wrap
      out_re <= ncb_pkg::ncb_sat16(re_full);
      out_im <= real_mode ? 16'sh0000
        : ncb_pkg::ncb_sat16(im_full);
    end
  end
endmodule : ncb_mixer

// file: design/ncb_halfband.sv
// Double-rate half-band interpolator, two output samples per clock
`timescale 1ns/1ps
`include "ncb_regs.svh"
module ncb_halfband (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic en,
  input wire logic highpass,
  input wire logic signed [15:0] din,
  output logic signed [15:0] dout_even,
  output logic signed [15:0] dout_odd
);
  localparam logic signed [11:0] coef [8] = `NCB_HB_COEFS;
  logic signed [15:0] tap [16];
  logic signed [31:0] prod [8];
  logic signed [35:0] acc;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tap <= '{default: 16'sh0000};
    end else if (en) begin
      tap <= {din, tap[0:14]};
    end
  end

  // Symmetric pairs share one multiplier
  genvar k;
  generate
    for (k = 0; k < 8; k++) begin : g_pair
      assign prod[k] = 32'(17'(tap[k]) + 17'(tap[15 - k])) * coef[k];
    end
  endgenerate

  always_comb begin
    acc = 36'sh0_0000_0400;
    for (int j = 0; j < 8; j++) begin
      acc = acc + 36'(prod[j]);
    end
    acc = acc >>> `NCB_HB_SHIFT;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dout_even <= 16'sh0000;
      dout_odd <= 16'sh0000;
    end else if (en) begin
      // Centre tap 2048 scaled by 2^-11 is unity on this phase
      dout_even <= tap[8];
      // Highpass flips the sign of the outer-tap phase
      dout_odd <= highpass ? ncb_pkg::ncb_sat16(-acc)
        : ncb_pkg::ncb_sat16(acc);
    end
  end
endmodule : ncb_halfband

// file: tb/ncb_checker.sv
// Port-level timing assertions for ncb_top
`timescale 1ns/1ps
module ncb_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic in_valid,
  input wire logic nco_update,
  input wire logic dac_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_r_held;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_stands: assert property (s_r_held |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready during rvalid");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("awready during bvalid");
  a_valid_delay:
    assert property (in_valid |-> ##4 dac_valid) else $error("late");
  a_valid_idle:
    assert property (!in_valid |-> ##4 !dac_valid) else $error("early");
  a_update_pulse:
    assert property (nco_update |=> !nco_update) else $error("long");
endmodule : ncb_checker

bind ncb_top ncb_checker u_chk (.aclk, .aresetn, .s_axi_awready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .in_valid,
  .nco_update, .dac_valid);

// file: tb/ncb_source.sv
// Sample source model with in-band sync bursts on converter 0
`timescale 1ns/1ps
module ncb_source (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic [3:0] n_high,
  input wire logic signed [15:0] base_i,
  input wire logic signed [15:0] lo_cos,
  input wire logic signed [15:0] lo_sin,
  output logic in_valid = 1'b0,
  output logic signed [15:0] duc_i [4],
  output logic signed [15:0] duc_q [4],
  output logic signed [15:0] nco_cos [4],
  output logic signed [15:0] nco_sin [4],
  output logic last
);
  logic [3:0] step = 4'h0;
  // Steps 1..4 low, then n_high high samples
  assign last = step == 4'h4 + n_high;
  always @(posedge aclk) begin
    in_valid <= aresetn;
    if (!aresetn || !(start || (step != 4'h0 && !last))) begin
      step <= 4'h0;
    end else begin
      step <= start ? 4'h1 : step + 4'h1;
    end
  end
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      duc_i[k] = base_i;
      duc_q[k] = -base_i;
      nco_cos[k] = lo_cos;
      nco_sin[k] = lo_sin;
    end
    duc_i[0][0] = step > 4'h4;
  end
endmodule : ncb_source

// file: tb/test_nco_sync_bonder_des_interp.sv
// Register-driven regression of the up-conversion back end
`timescale 1ns/1ps
`include "ncb_regs.svh"
module test_nco_sync_bonder_des_interp;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, rd, ev = 32'h0, p;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sysref = 1'b0;
  logic fast_reconfig_frame_strobe = 1'b0, start = 1'b0;
  logic [3:0] n_high = 4'h4;
  logic signed [15:0] base_i = 16'sh0, lo_cos = 16'sh0, lo_sin = 16'sh0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, in_valid, nco_update, dac_valid, last;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata;
  logic signed [15:0] duc_i [4], duc_q [4], nco_cos [4], nco_sin [4];
  logic signed [15:0] dac_even, dac_odd, dac_q;
  logic signed [16:0] s;
  logic [15:0] nco_phase [4];
  logic [15:0] gexp [3] = '{16'h7fff, 16'h4000, 16'h2000};
  logic [31:0] tctrl [3] = '{32'h22, 32'h2c, 32'h24};
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;

  ncb_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .in_valid, .duc_i, .duc_q,
    .nco_cos, .nco_sin, .sysref, .fast_reconfig_frame_strobe, .nco_phase,
    .nco_update, .dac_valid, .dac_even, .dac_odd, .dac_q);
  ncb_source src (.aclk, .aresetn, .start, .n_high, .base_i, .lo_cos,
    .lo_sin, .in_valid, .duc_i, .duc_q, .nco_cos, .nco_sin, .last);

  initial forever #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      final_report();
    end
  end

  // ==========
  // Bus and compare tasks
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr

  task automatic evchk();
    rdr(`NCB_STATUS);
    chk("events", {24'h0, rd[15:8]}, ev);
  endtask : evchk

  // Burst of four lows then nh highs; update follows only a full run
  task automatic sync(input logic [3:0] nh, input logic e);
    @(posedge aclk);
    n_high <= nh;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    wait (last === 1'b1);
    @(posedge aclk);
    #1;
    chk("sync_update", {31'h0, nco_update}, {31'h0, e});
    ev = ev + e;
  endtask : sync

  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  // ==========
  // Main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(`NCB_CTRL);
    chk("ctrl_reset", rd, `NCB_CTRL_RST);
    rdr(8'h24);
    chk("unmapped_rd", {rd[31:2], resp}, {30'h0, `NCB_RESP_ERR});
    wr(8'h24, 32'h1);
    chk("unmapped_wr", {30'h0, resp}, {30'h0, `NCB_RESP_ERR});
    $display("test registers done");
    for (int k = 0; k < 4; k++) wr(8'(`NCB_FREQ0 + 4 * k), 32'h01234567);
    wr(`NCB_NCO_MODE, 32'h65);
    wr(`NCB_CTRL, 32'h21);
    wr(`NCB_CTRL, 32'h20);
    repeat (20) @(posedge aclk);
    for (int k = 0; k < 4; k++) wr(8'(`NCB_FREQ0 + 4 * k), 32'h0);
    wr(`NCB_CTRL, 32'h21);
    wr(`NCB_CTRL, 32'h20);
    ev = 32'h2;
    repeat (5) @(posedge aclk);
    p = {16'h0, nco_phase[1]};
    repeat (3) @(posedge aclk);
    chk("phase0", {16'h0, nco_phase[0]}, 32'h0);
    chk("phase2", {16'h0, nco_phase[2]}, 32'h0);
    chk("phase3", {16'h0, nco_phase[3]}, 32'h0);
    chk("phase1", {16'h0, nco_phase[1]}, p);
    chk("phase1_live", {31'h0, p != 32'h0}, 32'h1);
    evchk();
    $display("test modes done");
    wr(`NCB_CTRL, 32'h27);
    rdr(`NCB_STATUS);
    chk("lsb_on", {31'h0, rd[0]}, 32'h1);
    sync(4'h4, 1'b1);
    sync(4'h3, 1'b0);
    wr(`NCB_CTRL, 32'h07);
    sync(4'h4, 1'b0);
    wr(`NCB_CTRL, 32'h37);
    sync(4'h4, 1'b1);
    rdr(`NCB_CTRL);
    chk("auto_clear", rd, 32'h36);
    for (int k = 0; k < 3; k++) begin
      wr(`NCB_CTRL, tctrl[k]);
      sysref <= 1'b1;
      fast_reconfig_frame_strobe <= 1'b1;
      repeat (3) @(posedge aclk);
      sysref <= 1'b0;
      fast_reconfig_frame_strobe <= 1'b0;
      repeat (6) @(posedge aclk);
      ev = ev + (k < 2);
      evchk();
    end
    $display("test sync done");
    base_i <= 16'sh7fff;
    lo_cos <= 16'sh7fff;
    lo_sin <= 16'sh7fff;
    wr(`NCB_CTRL, 32'h20);
    for (int g = 0; g < 4; g++) begin
      if (g == 3) wr(`NCB_SUM_SRC, 32'h7);
      if (g == 3) wr(`NCB_CTRL, 32'h60);
      wr(`NCB_GAIN, 32'h55 * (g % 3 + 2 * (g / 3)));
      repeat (12) @(posedge aclk);
      p = (g == 3) ? 32'h5fff : {16'h0, gexp[g % 3]};
      chk("bond_even", {16'h0, dac_even}, p);
      chk("bond_odd", {16'h0, dac_odd}, p);
      chk("bond_q", {16'h0, dac_q}, 32'h0);
    end
    $display("test bonder done");
    base_i <= 16'sh0800;
    lo_cos <= 16'sh0;
    lo_sin <= 16'sh0;
    for (int m = 0; m < 2; m++) begin
      wr(`NCB_CTRL, m ? 32'h320 : 32'h2a0);
      repeat (40) @(posedge aclk);
      s = dac_even + dac_odd;
      chk("des_sum", {15'h0, s}, m ? 32'h8 : 32'hff8);
    end
    $display("test filter done");
    final_report();
  end
endmodule : test_nco_sync_bonder_des_interp
